// ==== dsrx_pkg.sv ====
// Shared constants for the deserializer receive output port
package dsrx_pkg;
  localparam int DSRX_CHAR_W = 10;
  localparam int DSRX_STAT_W = 2;
  localparam logic [1:0] DSRX_SELFTEST_RECEIVE = 2'h2;
  localparam logic DSRX_RATE_HALF = 1'h1;
  localparam logic DSRX_RATE_FULL = 1'h0;
  localparam int DSRX_REF_CLK_MHZ = 50;
  localparam int DSRX_LINK_PERIOD_NS = 160;
  localparam int DSRX_REF_PERIOD_NS = 1000 / DSRX_REF_CLK_MHZ;
  localparam int DSRX_LOCK_WINDOW_CYC = (DSRX_LINK_PERIOD_NS * 4) / DSRX_REF_PERIOD_NS;
  localparam int DSRX_LOCK_CNT_W = 8;
  localparam logic [7:0] DSRX_LOCK_STABLE = 8'h04;
  localparam int DSRX_IRQ_W = 4;
  localparam logic [3:0] DSRX_ADDR_STATUS = 4'h0;
  localparam logic [3:0] DSRX_ADDR_CLEAR = 4'h1;
  localparam logic [3:0] DSRX_ADDR_ENABLE = 4'h2;
  localparam logic [3:0] DSRX_ADDR_CTRL = 4'h3;
  localparam logic [3:0] DSRX_ADDR_STATE = 4'h4;
  localparam int DSRX_CTRL_BIST_LSB = 0;
  localparam int DSRX_CTRL_RATE = 2;
  localparam int DSRX_CTRL_ROE1 = 3;
  localparam int DSRX_CTRL_ROE2 = 4;
  localparam int DSRX_CTRL_ULC = 5;
  localparam int DSRX_CTRL_B_OFS = 8;
  localparam logic [31:0] DSRX_CTRL_RESET = 32'h00003838;
  localparam int DSRX_EV_LOCK_A = 0;
  localparam int DSRX_EV_LOCK_B = 1;
  localparam int DSRX_EV_ERR_A = 2;
  localparam int DSRX_EV_ERR_B = 3;
  typedef enum logic [1:0] {
    DSRX_BIST_IDLE = 2'b00,
    DSRX_BIST_GOOD = 2'b01,
    DSRX_BIST_ERROR = 2'b10,
    DSRX_BIST_DONE = 2'b11
  } dsrx_bist_e;
endpackage

// ==== dsrx_sync.sv ====
// Two-flop synchroniser for one level
`timescale 1ns/1ns
`default_nettype none
module dsrx_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Level
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ==== dsrx_chan.sv ====
// One receive channel: clock pair, character output and self-test status
`timescale 1ns/1ns
`default_nettype none
module dsrx_chan
  import dsrx_pkg::*;
#(
  parameter int CHAR_W = DSRX_CHAR_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Synchronised link side
  input wire logic link_clk,
  input wire logic [CHAR_W-1:0] link_char,
  input wire logic link_valid,
  // Control
  input wire logic [1:0] receive_selftest_control,
  input wire logic receive_clock_rate_select,
  input wire logic force_local_reference,
  // Outputs
  output logic recovered_clock_p,
  output logic recovered_clock_n,
  output logic reclock_clock_out,
  output logic [CHAR_W-1:0] parallel_char,
  output logic selftest_status,
  output logic link_fault_indicator,
  output logic locked,
  output logic err_event,
  output logic lock_event
);
  import dsrx_pkg::*;
  logic link_clk_d;
  logic link_rise;
  logic [7:0] edge_gap;
  logic [7:0] stable_cnt;
  logic [CHAR_W-1:0] expect_char;
  logic bist_err;
  logic bist_seen;
  logic bist_mode;
  logic char_step;
  dsrx_bist_e bist_state;

  assign link_rise = link_clk & ~link_clk_d;
  assign bist_mode = receive_selftest_control == DSRX_SELFTEST_RECEIVE;
  assign char_step = link_rise & link_valid;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link_clk_d <= 1'b0;
    end else if (clk_en) begin
      link_clk_d <= link_clk;
    end
  end

  // Lock follows link edges within the window; dropped while force_local_reference is low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      edge_gap <= 8'h00;
      stable_cnt <= 8'h00;
      locked <= 1'b0;
    end else if (clk_en) begin
      if (!force_local_reference) begin
        stable_cnt <= 8'h00;
        locked <= 1'b0;
      end else if (link_rise) begin
        edge_gap <= 8'h00;
        if (stable_cnt != DSRX_LOCK_STABLE) begin
          stable_cnt <= stable_cnt + 8'h01;
        end
        locked <= (stable_cnt == DSRX_LOCK_STABLE);
      end else if (edge_gap == 8'(DSRX_LOCK_WINDOW_CYC)) begin
        stable_cnt <= 8'h00;
        locked <= 1'b0;
      end else begin
        edge_gap <= edge_gap + 8'h01;
      end
    end
  end
  assign lock_event = clk_en & link_rise & force_local_reference & ~locked & (stable_cnt == DSRX_LOCK_STABLE);
  assign link_fault_indicator = locked & force_local_reference;

  // Clock pair: toggles per character; full rate also falls mid-character
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      recovered_clock_p <= 1'b0;
      recovered_clock_n <= 1'b1;
      reclock_clock_out <= 1'b0;
    end else if (clk_en) begin
      reclock_clock_out <= link_clk_d;
      if (link_rise) begin
        // Toggle, so a rate change never leaves a data step without an edge
        recovered_clock_p <= ~recovered_clock_p;
        recovered_clock_n <= recovered_clock_p;
      end else if (receive_clock_rate_select == DSRX_RATE_FULL && !link_clk_d) begin
        recovered_clock_p <= 1'b0;
        recovered_clock_n <= 1'b1;
      end
    end
  end

  // Characters update on every output clock edge used for data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      parallel_char <= '0;
      selftest_status <= 1'b0;
    end else if (clk_en && char_step) begin
      if (bist_mode) begin
        parallel_char <= {{(CHAR_W-DSRX_STAT_W){1'b0}}, bist_state};
        selftest_status <= bist_seen;
      end else begin
        parallel_char <= link_char;
        selftest_status <= 1'b0;
      end
    end
  end

  // Self-test checker: expects an incrementing character sequence
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      expect_char <= '0;
      bist_err <= 1'b0;
      bist_seen <= 1'b0;
      bist_state <= DSRX_BIST_IDLE;
    end else if (clk_en) begin
      if (!bist_mode) begin
        bist_seen <= 1'b0;
        bist_err <= 1'b0;
        bist_state <= DSRX_BIST_IDLE;
      end else if (char_step) begin
        bist_seen <= 1'b1;
        expect_char <= link_char + CHAR_W'(1);
        bist_err <= bist_seen && (link_char != expect_char);
        unique case (bist_state)
          DSRX_BIST_IDLE: bist_state <= DSRX_BIST_GOOD;
          DSRX_BIST_GOOD, DSRX_BIST_ERROR, DSRX_BIST_DONE: begin
            // Error stays while mismatches continue
            if (link_char != expect_char) begin
              bist_state <= DSRX_BIST_ERROR;
            end else if (&link_char) begin
              bist_state <= DSRX_BIST_DONE;
            end else begin
              bist_state <= DSRX_BIST_GOOD;
            end
          end
        endcase
      end
    end
  end
  assign err_event = clk_en & char_step & bist_mode & bist_seen & (link_char != expect_char);
endmodule
`default_nettype wire

// ==== dsrx_port.sv ====
// Dual receive output port with Avalon-MM control and interrupt
`timescale 1ns/1ns
`default_nettype none
module dsrx_port
  import dsrx_pkg::*;
#(
  parameter int CHAR_W = DSRX_CHAR_W
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // Channel A link side
  input wire logic chan_a_training_clock,
  input wire logic chan_a_link_clock,
  input wire logic [CHAR_W-1:0] chan_a_link_char,
  input wire logic chan_a_link_valid,
  // Channel B link side
  input wire logic chan_b_training_clock,
  input wire logic chan_b_link_clock,
  input wire logic [CHAR_W-1:0] chan_b_link_char,
  input wire logic chan_b_link_valid,
  // Channel A outputs
  output logic [CHAR_W-1:0] chan_a_parallel_char,
  output logic chan_a_recovered_clock_p,
  output logic chan_a_recovered_clock_n,
  output logic chan_a_reclock_clock_out,
  output logic chan_a_selftest_status,
  output logic chan_a_reclock_powered_down,
  output logic chan_a_link_fault_indicator,
  // Channel B outputs
  output logic [CHAR_W-1:0] chan_b_parallel_char,
  output logic chan_b_recovered_clock_p,
  output logic chan_b_recovered_clock_n,
  output logic chan_b_reclock_clock_out,
  output logic chan_b_selftest_status,
  output logic chan_b_reclock_powered_down,
  output logic chan_b_link_fault_indicator
);
  import dsrx_pkg::*;
  logic [31:0] ctrl;
  logic [DSRX_IRQ_W-1:0] irq_status;
  logic [DSRX_IRQ_W-1:0] irq_enable;
  logic [DSRX_IRQ_W-1:0] irq_event;
  logic [DSRX_IRQ_W-1:0] irq_clear;
  logic rd_pending;
  logic a_lclk, b_lclk, a_tclk, b_tclk, a_valid, b_valid;
  logic [CHAR_W-1:0] a_char_s1, a_char, b_char_s1, b_char;
  logic a_sel_clk, b_sel_clk;
  logic a_locked, b_locked, a_err, b_err, a_lock_ev, b_lock_ev;
  logic a_reclk, b_reclk;

  // Link pins pass two flops before use
  dsrx_sync u_sync_alc (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .async_in(chan_a_link_clock), .sync_out(a_lclk));
  dsrx_sync u_sync_blc (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .async_in(chan_b_link_clock), .sync_out(b_lclk));
  dsrx_sync u_sync_atc (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .async_in(chan_a_training_clock),
    .sync_out(a_tclk));
  dsrx_sync u_sync_btc (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .async_in(chan_b_training_clock),
    .sync_out(b_tclk));
  dsrx_sync u_sync_av (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .async_in(chan_a_link_valid), .sync_out(a_valid));
  dsrx_sync u_sync_bv (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .async_in(chan_b_link_valid), .sync_out(b_valid));

  // Character words, stable around link edges, double-flopped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      a_char_s1 <= '0;
      a_char <= '0;
      b_char_s1 <= '0;
      b_char <= '0;
    end else if (clk_en) begin
      a_char_s1 <= chan_a_link_char;
      a_char <= a_char_s1;
      b_char_s1 <= chan_b_link_char;
      b_char <= b_char_s1;
    end
  end

  // Loop reference: training clock when forced local or no data
  assign a_sel_clk = (ctrl[DSRX_CTRL_ULC] && a_valid) ? a_lclk : a_tclk;
  assign b_sel_clk = (ctrl[DSRX_CTRL_B_OFS+DSRX_CTRL_ULC] && b_valid) ? b_lclk : b_tclk;

  // Independent channel instances
  dsrx_chan #(.CHAR_W(CHAR_W)) u_chan_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .link_clk(a_sel_clk),
    .link_char(a_char),
    .link_valid(a_valid | ~ctrl[DSRX_CTRL_ULC]),
    .receive_selftest_control(ctrl[DSRX_CTRL_BIST_LSB +: 2]),
    .receive_clock_rate_select(ctrl[DSRX_CTRL_RATE]),
    .force_local_reference(ctrl[DSRX_CTRL_ULC]),
    .recovered_clock_p(chan_a_recovered_clock_p),
    .recovered_clock_n(chan_a_recovered_clock_n),
    .reclock_clock_out(a_reclk),
    .parallel_char(chan_a_parallel_char),
    .selftest_status(chan_a_selftest_status),
    .link_fault_indicator(chan_a_link_fault_indicator),
    .locked(a_locked),
    .err_event(a_err),
    .lock_event(a_lock_ev)
  );
  dsrx_chan #(.CHAR_W(CHAR_W)) u_chan_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .link_clk(b_sel_clk),
    .link_char(b_char),
    .link_valid(b_valid | ~ctrl[DSRX_CTRL_B_OFS+DSRX_CTRL_ULC]),
    .receive_selftest_control(ctrl[DSRX_CTRL_B_OFS+DSRX_CTRL_BIST_LSB +: 2]),
    .receive_clock_rate_select(ctrl[DSRX_CTRL_B_OFS+DSRX_CTRL_RATE]),
    .force_local_reference(ctrl[DSRX_CTRL_B_OFS+DSRX_CTRL_ULC]),
    .recovered_clock_p(chan_b_recovered_clock_p),
    .recovered_clock_n(chan_b_recovered_clock_n),
    .reclock_clock_out(b_reclk),
    .parallel_char(chan_b_parallel_char),
    .selftest_status(chan_b_selftest_status),
    .link_fault_indicator(chan_b_link_fault_indicator),
    .locked(b_locked),
    .err_event(b_err),
    .lock_event(b_lock_ev)
  );

  // Reclock clock: receive clock at select 0, sampled link clock at 1
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chan_a_reclock_clock_out <= 1'b0;
      chan_b_reclock_clock_out <= 1'b0;
    end else if (clk_en) begin
      chan_a_reclock_clock_out <= ctrl[DSRX_CTRL_RATE] ? a_reclk : chan_a_recovered_clock_p;
      chan_b_reclock_clock_out <= ctrl[DSRX_CTRL_B_OFS+DSRX_CTRL_RATE] ? b_reclk : chan_b_recovered_clock_p;
    end
  end

  // Powered-down status, decoded from control bits without a clock
  assign chan_a_reclock_powered_down = ~ctrl[DSRX_CTRL_ROE1] & ~ctrl[DSRX_CTRL_ROE2];
  assign chan_b_reclock_powered_down =
    ~ctrl[DSRX_CTRL_B_OFS+DSRX_CTRL_ROE1] & ~ctrl[DSRX_CTRL_B_OFS+DSRX_CTRL_ROE2];

  // Control register with byte enables
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl <= DSRX_CTRL_RESET;
    end else if (clk_en && avs_write && !avs_waitrequest && avs_address == DSRX_ADDR_CTRL) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i]) begin
          ctrl[i*8 +: 8] <= avs_writedata[i*8 +: 8];
        end
      end
    end
  end

  // Interrupt enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_enable <= '0;
    end else if (clk_en && avs_write && !avs_waitrequest && avs_address == DSRX_ADDR_ENABLE && avs_byteenable[0]) begin
      irq_enable <= avs_writedata[DSRX_IRQ_W-1:0];
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_comb begin
    irq_event = '0;
    irq_event[DSRX_EV_LOCK_A] = a_lock_ev;
    irq_event[DSRX_EV_LOCK_B] = b_lock_ev;
    irq_event[DSRX_EV_ERR_A] = a_err;
    irq_event[DSRX_EV_ERR_B] = b_err;
  end
  assign irq_clear = (avs_write && !avs_waitrequest && avs_address == DSRX_ADDR_CLEAR && avs_byteenable[0]) ?
    avs_writedata[DSRX_IRQ_W-1:0] : '0;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end
  assign irq = |(irq_status & irq_enable);

  // One wait cycle on reads, writes taken at once
  assign avs_waitrequest = avs_read & ~rd_pending;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_pending <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else if (clk_en) begin
      rd_pending <= avs_read & ~rd_pending;
      if (avs_read && !rd_pending) begin
        unique case (avs_address)
          DSRX_ADDR_STATUS: avs_readdata <= 32'(irq_status);
          DSRX_ADDR_ENABLE: avs_readdata <= 32'(irq_enable);
          DSRX_ADDR_CTRL: avs_readdata <= ctrl;
          DSRX_ADDR_STATE: avs_readdata <= {28'h0000000, b_locked, a_locked,
            chan_b_reclock_powered_down, chan_a_reclock_powered_down};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== dsrx_port_assertions.sv ====
// Port-level checker for the deserializer receive output port
`timescale 1ns/1ns
`default_nettype none
module dsrx_port_assertions
  import dsrx_pkg::*;
#(
  parameter int CHAR_W = DSRX_CHAR_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Channel outputs
  input wire logic [CHAR_W-1:0] chan_a_parallel_char,
  input wire logic chan_a_recovered_clock_p,
  input wire logic chan_a_recovered_clock_n,
  input wire logic chan_b_recovered_clock_p,
  input wire logic chan_b_recovered_clock_n,
  input wire logic chan_a_reclock_powered_down,
  input wire logic chan_b_reclock_powered_down,
  input wire logic chan_a_link_fault_indicator
);
  import dsrx_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic ctrl_wr;
  assign ctrl_wr = avs_write && (avs_address == DSRX_ADDR_CTRL);

  property p_clk_a;
    chan_a_recovered_clock_p != chan_a_recovered_clock_n;
  endproperty
  a_clk_a: assert property (p_clk_a) else $error("clock pair A not complementary");
  property p_clk_b;
    chan_b_recovered_clock_p != chan_b_recovered_clock_n;
  endproperty
  a_clk_b: assert property (p_clk_b) else $error("clock pair B not complementary");
  property p_data_edge;
    $changed(chan_a_parallel_char) |-> $changed(chan_a_recovered_clock_p);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data A moved without clock edge");
  property p_pd_a;
    ctrl_wr && avs_byteenable[0] |=> chan_a_reclock_powered_down == (($past(avs_writedata) & 32'h18) == 32'h0);
  endproperty
  a_pd_a: assert property (p_pd_a) else $error("powered-down A wrong after write");
  property p_pd_b;
    ctrl_wr && avs_byteenable[1] |=> chan_b_reclock_powered_down == (($past(avs_writedata) & 32'h1800) == 32'h0);
  endproperty
  a_pd_b: assert property (p_pd_b) else $error("powered-down B wrong after write");
  property p_local;
    ctrl_wr && avs_byteenable[0] && !avs_writedata[5] |-> ##[1:3] !chan_a_link_fault_indicator;
  endproperty
  a_local: assert property (p_local) else $error("fault A not low on local reference");
  property p_wait_rd;
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_rd: assert property (p_wait_rd) else $error("read wait state wrong");
  property p_wait_wr;
    avs_write |-> !avs_waitrequest;
  endproperty
  a_wait_wr: assert property (p_wait_wr) else $error("write stalled");
  property p_unmapped;
    avs_read && !avs_waitrequest && (avs_address > DSRX_ADDR_STATE) |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset;
    disable iff (1'b0) rst ##1 rst |->
      chan_a_recovered_clock_n && !chan_a_recovered_clock_p && chan_a_parallel_char == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not at reset values");
  c_lock: cover property ($rose(chan_a_link_fault_indicator));
  c_pd: cover property ($rose(chan_a_reclock_powered_down));
  c_read: cover property ($rose(avs_read));
endmodule
bind dsrx_port dsrx_port_assertions #(.CHAR_W(CHAR_W)) u_chk (.ref_clk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .chan_a_parallel_char,
  .chan_a_recovered_clock_p, .chan_a_recovered_clock_n, .chan_b_recovered_clock_p, .chan_b_recovered_clock_n,
  .chan_a_reclock_powered_down, .chan_b_reclock_powered_down, .chan_a_link_fault_indicator);
`default_nettype wire

// ==== dsrx_link_model.sv ====
// Link-side source model: recovered character clock and characters
`timescale 1ns/1ns
`default_nettype none
module dsrx_link_model (
  // Control from the bench
  input wire logic run,
  input wire logic count_up,
  input wire logic [9:0] char_in,
  // Link side of the port
  output logic link_clock,
  output logic [9:0] link_char,
  output logic link_valid
);
  initial begin
    link_clock = 1'b0;
    link_char = 10'h000;
  end
  assign link_valid = run;
  // Clock stands low outside bursts
  always #80 link_clock = run ? ~link_clock : 1'b0;
  // New character at falling edge, stable around rising edge
  always @(negedge link_clock) link_char <= count_up ? link_char + 10'h001 : char_in;
  // Released lines keep moving
  always #20 if (!run) link_char = ~link_char;
endmodule
`default_nettype wire

// ==== test_deserializer_rx_output_port.sv ====
// Self-checking bench for the deserializer receive output port
`timescale 1ns/1ns
`default_nettype none
module test_deserializer_rx_output_port;
  import dsrx_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, avs_read = 1'b0, avs_write = 1'b0, irq, avs_waitrequest;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rnd = 32'hcb0f6602;
  logic chan_a_training_clock = 1'b0, chan_b_training_clock = 1'b0, run_a = 1'b0, run_b = 1'b0, up_a = 1'b0;
  logic [9:0] ch_a = 10'h000, ch_b = 10'h000, chan_a_link_char, chan_b_link_char;
  logic [9:0] chan_a_parallel_char, chan_b_parallel_char;
  logic chan_a_link_clock, chan_b_link_clock, chan_a_link_valid, chan_b_link_valid;
  logic chan_a_recovered_clock_p, chan_a_recovered_clock_n, chan_a_reclock_clock_out, chan_a_selftest_status;
  logic chan_b_recovered_clock_p, chan_b_recovered_clock_n, chan_b_reclock_clock_out, chan_b_selftest_status;
  logic chan_a_reclock_powered_down, chan_a_link_fault_indicator, chan_b_reclock_powered_down;
  logic chan_b_link_fault_indicator;
  int n_errors = 0, num_checks = 0;
  always #10 ref_clk = ~ref_clk;
  always #100 chan_a_training_clock = ~chan_a_training_clock;
  always #110 chan_b_training_clock = ~chan_b_training_clock;
  dsrx_link_model u_la (.run(run_a), .count_up(up_a), .char_in(ch_a), .link_clock(chan_a_link_clock),
    .link_char(chan_a_link_char), .link_valid(chan_a_link_valid));
  dsrx_link_model u_lb (.run(run_b), .count_up(1'b0), .char_in(ch_b), .link_clock(chan_b_link_clock),
    .link_char(chan_b_link_char), .link_valid(chan_b_link_valid));
  dsrx_port DUT (.ref_clk, .rst, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .irq, .chan_a_training_clock, .chan_a_link_clock, .chan_a_link_char,
    .chan_a_link_valid, .chan_b_training_clock, .chan_b_link_clock, .chan_b_link_char, .chan_b_link_valid,
    .chan_a_parallel_char, .chan_a_recovered_clock_p, .chan_a_recovered_clock_n, .chan_a_reclock_clock_out,
    .chan_a_selftest_status, .chan_a_reclock_powered_down, .chan_a_link_fault_indicator, .chan_b_parallel_char,
    .chan_b_recovered_clock_p, .chan_b_recovered_clock_n, .chan_b_reclock_clock_out, .chan_b_selftest_status,
    .chan_b_reclock_powered_down, .chan_b_link_fault_indicator);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic exp_pd(input logic [31:0] c);
    return c[4:3] == 2'b00;
  endfunction
  function automatic logic near(input int a, input int b);
    return (a >= b - 1) && (a <= b + 1);
  endfunction
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
      output logic [31:0] q);
    @(posedge ref_clk);
    avs_write <= we;
    avs_read <= !we;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
  initial begin
    logic [31:0] q;
    logic [31:0] c;
    int n_lk, n_rc, n_rk;
    logic p_lk, p_rc, p_rk;
    repeat (2) @(posedge ref_clk);
    check_bit("clock_n_reset", 1'b1, chan_a_recovered_clock_n);
    check_word("char_reset", 32'h0, {22'h0, chan_b_parallel_char});
    check_bit("reclock_b_reset", 1'b0, chan_b_reclock_clock_out);
    rst <= 1'b0;
    bus(1'b0, DSRX_ADDR_CTRL, 32'h0, 4'hF, q);
    check_word("ctrl_reset", DSRX_CTRL_RESET, q);
    bus(1'b1, 4'hF, 32'hFFFFFFFF, 4'hF, q);
    bus(1'b0, 4'hF, 32'h0, 4'hF, q);
    check_word("unmapped", 32'h0, q);
    for (int i = 0; i < 7; i++) begin
      c = (i < 4) ? ((DSRX_CTRL_RESET & ~32'h18) | (i << 3)) : rnd;
      bus(1'b1, DSRX_ADDR_CTRL, c, 4'h1, q);
      @(negedge ref_clk);
      check_bit("pd_a", exp_pd(c), chan_a_reclock_powered_down);
      check_bit("pd_b", 1'b0, chan_b_reclock_powered_down);
      bus(1'b0, DSRX_ADDR_STATE, 32'h0, 4'hF, q);
      check_bit("state_pd_a", exp_pd(c), q[0]);
      rnd = lfsr(rnd);
    end
    bus(1'b1, DSRX_ADDR_ENABLE, 32'h3, 4'hF, q);
    bus(1'b1, DSRX_ADDR_CTRL, 32'h3C3C, 4'hF, q);
    run_a <= 1'b1;
    run_b <= 1'b1;
    for (int k = 0; k < 300 && !(chan_a_link_fault_indicator && chan_b_link_fault_indicator); k++) @(posedge ref_clk);
    @(negedge ref_clk);
    check_bit("lock_a", 1'b1, chan_a_link_fault_indicator);
    check_bit("irq_lock", 1'b1, irq);
    bus(1'b0, DSRX_ADDR_STATUS, 32'h0, 4'hF, q);
    check_word("status_lock", 32'h3, q & 32'h3);
    bus(1'b1, DSRX_ADDR_CLEAR, 32'hF, 4'hF, q);
    bus(1'b0, DSRX_ADDR_STATUS, 32'h0, 4'hF, q);
    check_word("status_clear", 32'h0, q);
    check_bit("irq_clear", 1'b0, irq);
    for (int i = 0; i < 6; i++) begin
      ch_a <= (i == 0) ? 10'h3FF : rnd[9:0];
      ch_b <= (i == 1) ? 10'h000 : ~rnd[19:10];
      repeat (40) @(posedge ref_clk);
      check_word("char_a", {22'h0, ch_a}, {22'h0, chan_a_parallel_char});
      check_word("char_b", {22'h0, ch_b}, {22'h0, chan_b_parallel_char});
      rnd = lfsr(rnd);
    end
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, DSRX_ADDR_CTRL, 32'h38 | (r << 2), 4'h1, q);
      repeat (40) @(posedge ref_clk);
      {n_lk, n_rc, n_rk} = '0;
      {p_lk, p_rc, p_rk} = {chan_a_link_clock, chan_a_recovered_clock_p, chan_a_reclock_clock_out};
      repeat (320) begin
        @(negedge ref_clk);
        n_lk += int'(chan_a_link_clock && !p_lk);
        n_rc += int'(chan_a_recovered_clock_p != p_rc);
        n_rk += int'(chan_a_reclock_clock_out != p_rk);
        {p_lk, p_rc, p_rk} = {chan_a_link_clock, chan_a_recovered_clock_p, chan_a_reclock_clock_out};
      end
      check_bit("rx_clock_rate", 1'b1, near(n_rc, (2 - r) * n_lk));
      check_bit("reclock_rate", 1'b1, near(n_rk, (r + 1) * (2 - r) * n_lk));
    end
    bus(1'b1, DSRX_ADDR_ENABLE, 32'h0, 4'hF, q);
    ch_a <= 10'h100;
    up_a <= 1'b1;
    bus(1'b1, DSRX_ADDR_CTRL, 32'h3E, 4'h1, q);
    repeat (120) @(posedge ref_clk);
    check_bit("st_status", 1'b1, chan_a_selftest_status);
    check_word("st_good", 32'h1, {30'h0, chan_a_parallel_char[1:0]});
    check_word("st_other_chan", {22'h0, ch_b}, {22'h0, chan_b_parallel_char});
    check_bit("st_b_status", 1'b0, chan_b_selftest_status);
    up_a <= 1'b0;
    repeat (80) @(posedge ref_clk);
    check_word("st_error", 32'h2, {30'h0, chan_a_parallel_char[1:0]});
    check_bit("irq_masked", 1'b0, irq);
    bus(1'b1, DSRX_ADDR_ENABLE, 32'h4, 4'hF, q);
    @(negedge ref_clk);
    check_bit("irq_err", 1'b1, irq);
    bus(1'b1, DSRX_ADDR_CTRL, 32'h3C, 4'h1, q);
    repeat (60) @(posedge ref_clk);
    check_word("st_off_char", {22'h0, ch_a}, {22'h0, chan_a_parallel_char});
    bus(1'b1, DSRX_ADDR_CLEAR, 32'hF, 4'hF, q);
    @(negedge ref_clk);
    check_bit("irq_err_clear", 1'b0, irq);
    bus(1'b1, DSRX_ADDR_CTRL, 32'h1C, 4'h1, q);
    repeat (4) @(negedge ref_clk);
    check_bit("fault_local_a", 1'b0, chan_a_link_fault_indicator);
    check_bit("fault_b_kept", 1'b1, chan_b_link_fault_indicator);
    print_verdict();
  end
endmodule
`default_nettype wire
